// File: design/prom_ctrl.sv
// serial configuration memory pin control: data fifo, serialiser, cascade, jtag tap
// assumes all pins come from outside the clk domain; two-way pins resolved by the bench
`timescale 1ns/100ps

// word buffer between the array side and the serialiser
module prom_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_reg;
  logic [PW:0]      rd_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // honest full and empty from the extra pointer bit
  assign in_ready  = (wr_reg - rd_reg) != (PW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[PW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push) mem[wr_reg[PW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin wr_reg <= '0; rd_reg <= '0; end
    else
    begin
      wr_reg <= wr_reg + (PW+1)'(push);
      rd_reg <= rd_reg + (PW+1)'(pop);
    end
  end
endmodule

// How it works
// - oe/reset low: counter reset, data floats unless clamped
// - pull oe/reset low during power-on reset
// - oe/reset always active low, never inverted
// - chip enable high: standby, reset, float unless clamped
// - reconfigure instruction pulses reconfig pin low
// - cascade low only when enabled past terminal
// - count config clock rises when selected, enabled
// - float data in programming mode unless clamped
// - tms sampled on tck rise steps tap
// - undriven tms and tdi read as one; here only tms, through the bench pull-up, as tdi has no pull-up
// - tck edges alone advance jtag logic
// - tdi shifts into selected register
// - selected register shifts out on tdo
module prom_ctrl
#(
  parameter logic [prom_ctrl_pkg::ADDR_W-1:0] TERMINAL_COUNT = prom_ctrl_pkg::TERMINAL_COUNT_DEF
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire prom_ctrl_pkg::pin_in_t         pins,
  input  wire logic                           cclk_select,
  input  wire logic [prom_ctrl_pkg::WORD_W-1:0] data_word,
  input  wire logic                           data_valid,
  output logic                                data_ready,
  output prom_ctrl_pkg::tri_pin_t             serial_data_out,
  output prom_ctrl_pkg::tri_pin_t             oe_rst_drive,
  output prom_ctrl_pkg::tri_pin_t             reconfig_pulse_n,
  output logic                                cascade_enable_out_n,
  output prom_ctrl_pkg::tri_pin_t             tdo,
  output logic                                in_system_program_mode,
  output logic                                standby
);
  import prom_ctrl_pkg::*;

  pin_in_t sync1_reg, sync2_reg, prev_reg;
  logic [$clog2(POR_CYCLES+1)-1:0]   por_cnt_reg;
  logic [$clog2(PULSE_CYCLES+1)-1:0] pulse_cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              past_tc_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [3:0]        bits_reg;
  logic [WORD_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              load_ready;
  tap_state_t        tap_reg, tap_next;
  logic [IR_W-1:0]   ir_reg, ir_sh_reg;
  logic [31:0]       dr_sh_reg;
  logic              isp_reg, clamp_reg, clamp_val_reg, tdo_reg, tdo_oe_reg;

  // two flops on every pin; tms and tdi reset high so an undriven port idles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin sync1_reg <= PIN_IN_RST; sync2_reg <= PIN_IN_RST; prev_reg <= PIN_IN_RST; end
    else begin sync1_reg <= pins; sync2_reg <= sync1_reg; prev_reg <= sync2_reg; end
  end

  wire cclk_rise = sync2_reg.cclk & ~prev_reg.cclk;
  wire tck_rise  = sync2_reg.tck & ~prev_reg.tck;
  wire tck_fall  = ~sync2_reg.tck & prev_reg.tck;
  wire oe_high   = sync2_reg.oe_rst_n;         // fixed active-low sense, no inversion
  wire ce_low    = ~sync2_reg.ce_n;
  wire por_busy  = por_cnt_reg != '0;
  wire enabled   = ce_low & oe_high & ~por_busy;
  wire count_ev  = cclk_rise & cclk_select & enabled;

  // power-on reset holds the shared reset line low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) por_cnt_reg <= ($clog2(POR_CYCLES+1))'(POR_CYCLES);
    else if (por_busy) por_cnt_reg <= por_cnt_reg - 1'b1;
  end
  assign oe_rst_drive = '{out: 1'b0, oe: por_busy};

  // address counter and serialiser; a disable drops any partial word
  // upstream sees fifo space only, so a held valid pushes the word again on every cycle with space
  assign load_ready = enabled & ~past_tc_reg & (bits_reg == 4'h0);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin addr_reg <= '0; past_tc_reg <= 1'b0; bits_reg <= 4'h0; shift_reg <= '0; end
    else if (!enabled) begin addr_reg <= '0; past_tc_reg <= 1'b0; bits_reg <= 4'h0; end
    else if (count_ev)
    begin
      addr_reg    <= addr_reg + 1'b1;
      past_tc_reg <= past_tc_reg | (addr_reg == TERMINAL_COUNT);
      if (bits_reg != 4'h0) begin shift_reg <= shift_reg << 1; bits_reg <= bits_reg - 1'b1; end
    end
    else if (load_ready & fifo_valid) begin shift_reg <= fifo_data; bits_reg <= 4'h8; end
  end

  prom_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (data_word),
    .in_valid  (data_valid),
    .in_ready  (data_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (load_ready)
  );

  // data pin: floats when disabled, past the end, or programming, unless clamped
  wire data_drive = clamp_reg | (enabled & ~past_tc_reg & ~isp_reg);
  assign serial_data_out = '{out: clamp_reg ? clamp_val_reg : shift_reg[WORD_W-1], oe: data_drive};
  assign cascade_enable_out_n = ~(ce_low & oe_high & past_tc_reg);
  assign standby = ~ce_low;
  assign in_system_program_mode = isp_reg;

  // tap next state from tms sampled at the tck rise
  always_comb
  begin
    unique case (tap_reg)
      TAP_RESET:  tap_next = sync2_reg.tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = sync2_reg.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = sync2_reg.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = sync2_reg.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = sync2_reg.tms ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_next = sync2_reg.tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = sync2_reg.tms ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = sync2_reg.tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = sync2_reg.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = sync2_reg.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = sync2_reg.tms ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_next = sync2_reg.tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = sync2_reg.tms ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  wire ir_idcode = ir_reg == IR_IDCODE;
  // the new instruction lands on the same edge that leaves update-ir, so read it there
  wire [IR_W-1:0] ir_effective = (tap_reg == TAP_UP_IR) ? ir_sh_reg : ir_reg;
  wire dr_bit    = ir_idcode ? dr_sh_reg[0] : dr_sh_reg[31];
  wire rc_start  = tck_rise & (tap_next == TAP_IDLE) & (tap_reg != TAP_IDLE)
                   & (ir_effective == IR_RECONFIG);

  // tap, instruction and data shifting all step only on tck edges
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tap_reg <= TAP_RESET; ir_reg <= IR_IDCODE; ir_sh_reg <= '0; dr_sh_reg <= '0;
    end
    else if (tck_rise)
    begin
      tap_reg <= tap_next;
      if (tap_reg == TAP_RESET) ir_reg <= IR_IDCODE;
      if (tap_reg == TAP_UP_IR) ir_reg <= ir_sh_reg;
      if (tap_reg == TAP_CAP_IR) ir_sh_reg <= IR_CAPTURE;
      if (tap_reg == TAP_SH_IR) ir_sh_reg <= {sync2_reg.tdi, ir_sh_reg[IR_W-1:1]};
      if (tap_reg == TAP_CAP_DR) dr_sh_reg <= ir_idcode ? IDCODE_VAL : 32'h0000_0000;
      if (tap_reg == TAP_SH_DR)
        dr_sh_reg <= ir_idcode ? {sync2_reg.tdi, dr_sh_reg[31:1]} : {31'h0, sync2_reg.tdi} << 31;
    end
  end

  // tdo changes on the falling tck edge so the far end samples it stable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin tdo_reg <= 1'b1; tdo_oe_reg <= 1'b0; end
    else if (tck_fall)
    begin
      tdo_reg    <= (tap_reg == TAP_SH_IR) ? ir_sh_reg[0] : dr_bit;
      tdo_oe_reg <= (tap_reg == TAP_SH_IR) | (tap_reg == TAP_SH_DR);
    end
  end
  assign tdo = '{out: tdo_reg, oe: tdo_oe_reg};

  // instruction effects: programming mode, clamp, reconfiguration pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      isp_reg <= 1'b0; clamp_reg <= 1'b0; clamp_val_reg <= 1'b0; pulse_cnt_reg <= '0;
    end
    else
    begin
      if (tck_rise & (tap_reg == TAP_RESET)) begin isp_reg <= 1'b0; clamp_reg <= 1'b0; end
      if (tck_rise & (tap_reg == TAP_UP_IR))
      begin
        if (ir_sh_reg == IR_ISP_ON) isp_reg <= 1'b1;
        if (ir_sh_reg == IR_ISP_OFF) isp_reg <= 1'b0;
        clamp_reg <= ir_sh_reg == IR_CLAMP;
        if ((ir_sh_reg == IR_CLAMP) & ~clamp_reg) clamp_val_reg <= shift_reg[WORD_W-1];
      end
      if (rc_start) pulse_cnt_reg <= ($clog2(PULSE_CYCLES+1))'(PULSE_CYCLES);
      else if (pulse_cnt_reg != '0) pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end
  assign reconfig_pulse_n = '{out: 1'b0, oe: pulse_cnt_reg != '0};

  // checks
  sequence s_rc_go;
    rc_start;
  endsequence
  sequence s_rc_low;
    reconfig_pulse_n.oe [*8];
  endsequence
  a_reset_floats: assert property (@(posedge clk) disable iff (!rst_n)
    !oe_high & !clamp_reg |-> !serial_data_out.oe ##1 (addr_reg == '0))
    else $error("data driven while reset line low");
  a_por_holds_line: assert property (@(posedge clk) disable iff (!rst_n)
    por_busy |-> oe_rst_drive.oe & !oe_rst_drive.out)
    else $error("reset line released during power-on reset");
  a_standby_floats: assert property (@(posedge clk) disable iff (!rst_n)
    sync2_reg.ce_n & !clamp_reg |-> standby & !serial_data_out.oe
      ##1 !past_tc_reg & (addr_reg == '0))
    else $error("standby did not reset counter");
  a_reconfig_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    s_rc_go |=> s_rc_low)
    else $error("reconfiguration pulse too short");
  a_cascade_cond: assert property (@(posedge clk) disable iff (!rst_n)
    !cascade_enable_out_n |-> ce_low & oe_high & past_tc_reg)
    else $error("cascade enable low without cause");
  a_cascade_release: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sync2_reg.ce_n) | $fell(sync2_reg.oe_rst_n) |-> cascade_enable_out_n)
    else $error("cascade enable stayed low");
  a_addr_counts: assert property (@(posedge clk) disable iff (!rst_n)
    count_ev |=> addr_reg == $past(addr_reg) + 1'b1)
    else $error("address did not advance on clock edge");
  a_isp_floats: assert property (@(posedge clk) disable iff (!rst_n)
    isp_reg & !clamp_reg |-> !serial_data_out.oe)
    else $error("data driven in programming mode");
  a_tap_resets: assert property (@(posedge clk) disable iff (!rst_n)
    tck_rise & sync2_reg.tms & (tap_reg == TAP_SEL_IR) |=> tap_reg == TAP_RESET)
    else $error("tap missed reset transition");
  a_tdo_shift: assert property (@(posedge clk) disable iff (!rst_n)
    tck_fall & (tap_reg == TAP_SH_IR) |=> tdo.oe & (tdo.out == $past(ir_sh_reg[0])))
    else $error("tdo not showing instruction bit");
endmodule

// File: design/prom_ctrl_pkg.sv
// constants, types and pin groups for the serial configuration memory control block
// assumes a single 50 MHz system clock; all pins arrive unsynchronised
package prom_ctrl_pkg;
  localparam int WORD_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W     = 24;
  localparam int IR_W       = 8;
  localparam int CLK_PERIOD_NS = 20;
  // power-on reset hold time, least time so round up
  localparam int POR_TIME_NS   = 2000;
  localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // reconfiguration pulse width, least time so round up
  localparam int PULSE_TIME_NS = 1000;
  localparam int PULSE_CYCLES  = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [ADDR_W-1:0] TERMINAL_COUNT_DEF = 24'hFFFFFF;
  // instruction codes
  localparam logic [IR_W-1:0] IR_BYPASS   = 8'hFF;
  localparam logic [IR_W-1:0] IR_IDCODE   = 8'hFE;
  localparam logic [IR_W-1:0] IR_RECONFIG = 8'hEE;
  localparam logic [IR_W-1:0] IR_ISP_ON   = 8'hE8;
  localparam logic [IR_W-1:0] IR_ISP_OFF  = 8'hF0;
  localparam logic [IR_W-1:0] IR_CLAMP    = 8'hFA;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 8'h01;
  // identification value is arbitrary
  localparam logic [31:0] IDCODE_VAL = 32'h0123_4567;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UP_IR
  } tap_state_t;

  typedef struct packed {
    logic cclk;
    logic ce_n;
    logic oe_rst_n;
    logic tck;
    logic tms;
    logic tdi;
  } pin_in_t;

  typedef struct packed {
    logic out;
    logic oe;
  } tri_pin_t;

  // undriven tms and tdi idle high; tck resets low
  localparam pin_in_t PIN_IN_RST = '{cclk: 1'b0, ce_n: 1'b1, oe_rst_n: 1'b0,
                                     tck: 1'b0, tms: 1'b1, tdi: 1'b1};
endpackage

// File: verif/config_host_model.sv
// far-side model: configuration logic that clocks the memory, and a jtag controller
// assumes the bench clock clk; every pin changes at its falling edge
`timescale 1ns/100ps
module config_host_model (
  input  wire logic                    clk,
  input  wire prom_ctrl_pkg::tri_pin_t tdo,
  output logic                         cclk,
  output logic                         hold_low,
  output logic                         tck,
  output logic                         tms,
  output logic                         tms_en,
  output logic                         tdi
);
  import prom_ctrl_pkg::*;

  // config clock stands still outside frames
  initial
  begin
    cclk = 1'b0;
    hold_low = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tms_en = 1'b1;
    tdi = 1'b1;
  end

  // config clock rises at 160 ns period
  task automatic rises(input int n);
    repeat (n)
    begin
      cclk = 1'b1;
      repeat (4) @(negedge clk);
      cclk = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  // pull the shared oe/reset wire low, as an fpga holding off configuration
  task automatic hold(input logic v);
    hold_low = v;
  endtask

  // one 160 ns tck period; tdo read at the rise, as left by the last fall
  task automatic tck_cycle(input logic m, input logic d, output logic seen);
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge clk);
    seen = tdo.out;
    tck = 1'b1;
    repeat (4) @(negedge clk);
    tck = 1'b0;
  endtask

  // idle, through one shift, back to idle; data lsb first
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] got);
    logic s;
    tck_cycle(1'b1, 1'b1, s);
    if (ir)
      tck_cycle(1'b1, 1'b1, s);
    tck_cycle(1'b0, 1'b1, s);
    tck_cycle(1'b0, 1'b1, s);
    got = '0;
    for (int i = 0; i < n; i++)
    begin
      tck_cycle(i == n - 1, din[i], s);
      got[i] = s;
    end
    tck_cycle(1'b1, 1'b1, s);
    tck_cycle(1'b0, 1'b1, s);
  endtask

  // tms left floating must read as one, so five periods reach reset
  task automatic tap_reset;
    logic s;
    tms_en = 1'b0;
    repeat (5) tck_cycle(1'b0, 1'b1, s);
    tms_en = 1'b1;
    tck_cycle(1'b0, 1'b1, s);
  endtask
endmodule

// File: verif/serial_config_prom_control_bench.sv
// self-checking bench for the configuration memory pin control
// assumes config_host_model on the far side; inputs change on falling clk
`timescale 1ns/100ps
module serial_config_prom_control_bench;
  import prom_ctrl_pkg::*;
  localparam int TC_SIM = 16;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce_n = 1'b1;
  logic              sel = 1'b1;
  logic [WORD_W-1:0] word = '0;
  logic              valid = 1'b0;
  logic              ready;
  logic              cas_n;
  logic              isp;
  logic              stby;
  tri_pin_t          sdo;
  tri_pin_t          oe_drv;
  tri_pin_t          cf;
  tri_pin_t          tdo;
  logic              cclk;
  logic              hold_low;
  logic              tck;
  logic              tms;
  logic              tms_en;
  logic              tdi;
  logic              oe_wire;
  pin_in_t           pins;
  logic [31:0]       got;
  int                n_fail = 0;
  int                compares = 0;
  int                cycles = 0;
  int                pulse_len = 0;

  always #10 clk = ~clk;

  // open-drain wire with pull-up; floating tms pulled high
  assign oe_wire = !((oe_drv.oe && !oe_drv.out) || hold_low);
  assign pins = '{cclk: cclk, ce_n: ce_n, oe_rst_n: oe_wire,
                  tck: tck, tms: tms_en ? tms : 1'b1, tdi: tdi};

  prom_ctrl #(.TERMINAL_COUNT(ADDR_W'(TC_SIM))) u_dut (
    .clk(clk), .rst_n(rst_n), .pins(pins), .cclk_select(sel), .data_word(word),
    .data_valid(valid), .data_ready(ready), .serial_data_out(sdo), .oe_rst_drive(oe_drv),
    .reconfig_pulse_n(cf), .cascade_enable_out_n(cas_n), .tdo(tdo),
    .in_system_program_mode(isp), .standby(stby)
  );

  config_host_model u_host (
    .clk(clk), .tdo(tdo), .cclk(cclk), .hold_low(hold_low), .tck(tck), .tms(tms),
    .tms_en(tms_en), .tdi(tdi)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cycle ceiling, plus a count of cycles the reconfig pulse is driven
  always @(negedge clk)
  begin
    cycles++;
    if (cf.oe === 1'b1)
      pulse_len++;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic power_on;
    repeat (4) @(negedge clk);
    check("por in reset", oe_drv.oe, 1'b1);
    rst_n = 1'b1;
    repeat (POR_CYCLES - 4) @(negedge clk);
    check("por hold", oe_drv.oe, 1'b1);
    check("por level", oe_drv.out, 1'b0);
    repeat (8) @(negedge clk);
    check("por release", oe_drv.oe, 1'b0);
  endtask

  // offer one word and wait, bounded, until it is taken
  task automatic send(input logic [WORD_W-1:0] w);
    int t = 0;
    word = w;
    valid = 1'b1;
    while (ready !== 1'b1 && t < 50)
    begin
      @(negedge clk);
      t++;
    end
    check("data ready", ready, 1'b1);
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
  endtask

  // two words back to back msb first, then one rise past terminal count
  task automatic stream;
    logic [WORD_W-1:0] wds [2] = '{8'hA5, 8'h3C};
    ce_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int j = 0; j < 2; j++)
    begin
      send(wds[j]);
      for (int k = WORD_W - 1; k >= 0; k--)
      begin
        check("data bit", sdo.out, wds[j][k]);
        check("data drive", sdo.oe, 1'b1);
        u_host.rises(1);
      end
    end
    check("cascade at terminal", cas_n, 1'b1);
    u_host.rises(1);
    check("cascade past terminal", cas_n, 1'b0);
  endtask

  // disable and reset each clear cascade, float data, restart the count
  task automatic disable_paths;
    ce_n = 1'b1;
    repeat (4) @(negedge clk);
    check("cascade on disable", cas_n, 1'b1);
    check("standby", stby, 1'b1);
    check("float on disable", sdo.oe, 1'b0);
    ce_n = 1'b0;
    u_host.rises(TC_SIM);
    check("count after disable", cas_n, 1'b1);
    u_host.rises(1);
    check("cascade again", cas_n, 1'b0);
    u_host.hold(1'b1);
    repeat (4) @(negedge clk);
    check("cascade on reset", cas_n, 1'b1);
    check("float on reset", sdo.oe, 1'b0);
    u_host.hold(1'b0);
    repeat (4) @(negedge clk);
    u_host.rises(TC_SIM);
    check("count after reset", cas_n, 1'b1);
  endtask

  // instruction capture, id readout, reconfigure pulse, programming mode
  task automatic jtag_ops;
    int base;
    u_host.tap_reset();
    u_host.shift(1'b1, IR_W, 32'(IR_IDCODE), got);
    check("ir capture", got[IR_W-1:0], IR_CAPTURE);
    u_host.shift(1'b0, 32, 32'h0, got);
    check("id readout", got, IDCODE_VAL);
    base = pulse_len;
    u_host.shift(1'b1, IR_W, 32'(IR_RECONFIG), got);
    check("reconfig level", cf.out, 1'b0);
    check("reconfig drive", cf.oe, 1'b1);
    repeat (100) @(negedge clk);
    check("reconfig width", pulse_len - base, PULSE_CYCLES);
    u_host.shift(1'b1, IR_W, 32'(IR_ISP_ON), got);
    check("isp on", isp, 1'b1);
    check("float in isp", sdo.oe, 1'b0);
    u_host.shift(1'b1, IR_W, 32'(IR_CLAMP), got);
    check("drive when clamped", sdo.oe, 1'b1);
    u_host.tap_reset();
    check("isp cleared", isp, 1'b0);
  endtask

  initial
  begin
    power_on();
    stream();
    disable_paths();
    jtag_ops();
    complete_run();
  end
endmodule
